/* File: rtl/hpsc_ctl.sv */
// Controller end: AHB-Lite register slave that issues link
// transactions and emulates the embedded downstream port.
// Assumes the link's device end answers within one bit time.
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "hpsc_params.svh"

module hpsc_ctl
  import hpsc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Hub events
  input  wire logic        remote_wake,
  input  wire logic        hub_suspended,
  input  wire logic        emb_babble_seen,
  // Embedded function control
  output logic             emb_fn_cmd,
  output logic             emb_int_ep_en,
  output logic             emb_addr_zero,
  // Link to the device
  hpsc_link_if.ctl         link
);

  // Link frame word for the frame in progress
  function automatic logic [9:0] frame_word(input hpsc_ctl_st_t s);
    if (s.fidx == 2'h0) begin
      return {`HPSC_FT_CMD, s.cmdb};
    end
    return s.rd ? {`HPSC_FT_RD, 8'h00} : {`HPSC_FT_WR, s.wdat};
  endfunction : frame_word

  hpsc_ctl_st_t r_ff;
  hpsc_ctl_st_t nxt_r;
  logic         tick;
  logic         wr_ctrl;
  logic [9:0]   fw;
  logic         addr_ok;

  // =========================================================
  // Next state
  always_comb begin
    nxt_r           = r_ff;
    nxt_r.miso_m    = link.link_miso;
    nxt_r.miso_s    = r_ff.miso_m;
    nxt_r.addr_zero = 1'b0;
    fw              = frame_word(r_ff);
    // Only whole-word transfers are accepted; hsize must decode as word (3'h2)
    addr_ok         = hsel & htrans[1] & hready & (hsize == 3'h2);

    // AHB address phase; read data prepared for the data phase
    nxt_r.ahb_wr = addr_ok & hwrite;
    if (addr_ok) begin
      nxt_r.ahb_addr = haddr[7:0];
      unique case (haddr[7:0])
        `HPSC_A_STAT: nxt_r.hrdata = {30'h0, r_ff.wake_pend, r_ff.busy};
        `HPSC_A_RDAT: nxt_r.hrdata = {16'h0, r_ff.rdata};
        `HPSC_A_EMB:  nxt_r.hrdata = {25'h0, r_ff.int_ep_en, r_ff.fn_en, r_ff.susp_chg,
                                      r_ff.en_chg, r_ff.rst_chg, r_ff.susp, r_ff.en};
        default:      nxt_r.hrdata = 32'h0;
      endcase
    end

    // Launch an operation; writes while busy are ignored
    wr_ctrl = r_ff.ahb_wr & (r_ff.ahb_addr == `HPSC_A_CTRL) & ~r_ff.busy;
    if (wr_ctrl) begin
      nxt_r.busy = 1'b1;
      nxt_r.fidx = 2'h0;
      nxt_r.hc   = 5'h00;
      nxt_r.div  = 4'h0;
      nxt_r.rd   = 1'b0;
      nxt_r.fcnt = 2'h0;
      unique case (hwdata[2:0])
        `HPSC_OP_PSTAT: begin
          nxt_r.cmdb = `HPSC_CMD_PORT_STAT | {7'h00, hwdata[`HPSC_CTRL_PORT]};
          nxt_r.rd   = 1'b1;
          nxt_r.fcnt = hwdata[`HPSC_CTRL_TWO] ? 2'h2 : 2'h1;
        end
        `HPSC_OP_SETCHG: begin
          nxt_r.cmdb = `HPSC_CMD_SET_CHG;
          nxt_r.fcnt = 2'h1;
          nxt_r.wdat = 8'h00;
          nxt_r.wdat[`HPSC_CHG_LOCAL] = hwdata[`HPSC_CTRL_LPWR];
          nxt_r.wdat[`HPSC_CHG_EMB]   = r_ff.rst_chg | r_ff.en_chg | r_ff.susp_chg;
        end
        `HPSC_OP_RESUME: nxt_r.cmdb = `HPSC_CMD_RESUME;
        `HPSC_OP_FRAME: begin
          nxt_r.cmdb = `HPSC_CMD_FRAME_NUM;
          nxt_r.rd   = 1'b1;
          nxt_r.fcnt = hwdata[`HPSC_CTRL_TWO] ? 2'h2 : 2'h1;
        end
        default: nxt_r.busy = 1'b0;
      endcase
    end else if (~r_ff.busy & r_ff.wake_pend) begin
      // Pending remote wakeup sends the resume command
      nxt_r.busy      = 1'b1;
      nxt_r.wake_pend = 1'b0;
      nxt_r.fidx      = 2'h0;
      nxt_r.hc        = 5'h00;
      nxt_r.div       = 4'h0;
      nxt_r.rd        = 1'b0;
      nxt_r.fcnt      = 2'h0;
      nxt_r.cmdb      = `HPSC_CMD_RESUME;
    end

    // Link clock divider: one half period per tick
    tick = r_ff.busy & (r_ff.div == `HPSC_HALF_CYC - 4'h1);
    if (r_ff.busy) begin
      nxt_r.div = tick ? 4'h0 : r_ff.div + 4'h1;
    end
    if (tick) begin
      nxt_r.hc = r_ff.hc + 5'h01;
      if (r_ff.hc < 5'h14) begin
        if (~r_ff.hc[0]) begin
          nxt_r.sel  = 1'b1;
          nxt_r.sclk = 1'b0;
          nxt_r.mosi = fw[4'h9 - 4'(r_ff.hc[4:1])];
        end else begin
          nxt_r.sclk = 1'b1;
          if (r_ff.rd && r_ff.fidx != 2'h0 && r_ff.hc >= 5'h05) begin
            nxt_r.rx = {r_ff.rx[6:0], r_ff.miso_s};
          end
        end
      end else if (r_ff.hc == 5'h14) begin
        nxt_r.sclk = 1'b0;
      end else if (r_ff.hc == 5'h15) begin
        nxt_r.sel = 1'b0;
        if (r_ff.rd && r_ff.fidx == 2'h1) nxt_r.rdata[7:0] = r_ff.rx;
        if (r_ff.rd && r_ff.fidx == 2'h2) nxt_r.rdata[15:8] = r_ff.rx;
      end else if (r_ff.hc == `HPSC_LAST_HC) begin
        // Each data byte travels in its own frame
        nxt_r.hc = 5'h00;
        if (r_ff.fidx == r_ff.fcnt) begin
          nxt_r.busy = 1'b0;
        end else begin
          nxt_r.fidx = r_ff.fidx + 2'h1;
        end
      end
    end

    // Host requests for the embedded port
    if (r_ff.ahb_wr && r_ff.ahb_addr == `HPSC_A_HREQ) begin
      unique case (hwdata[3:0])
        `HPSC_HR_RESET: begin
          nxt_r.rst_chg   = 1'b1;
          nxt_r.en        = 1'b0;
          nxt_r.susp      = 1'b0;
          nxt_r.fn_en     = 1'b1;
          nxt_r.addr_zero = 1'b1;
          nxt_r.int_ep_en = 1'b0;
        end
        `HPSC_HR_ENABLE:   {nxt_r.fn_en, nxt_r.en} = 2'b11;
        `HPSC_HR_DISABLE:  {nxt_r.fn_en, nxt_r.en} = 2'b00;
        `HPSC_HR_SUSPEND:  {nxt_r.fn_en, nxt_r.en, nxt_r.susp} = 3'b001;
        `HPSC_HR_RESUME:   {nxt_r.fn_en, nxt_r.en, nxt_r.susp, nxt_r.susp_chg} = 4'b1101;
        `HPSC_HR_CLR_RST:  nxt_r.rst_chg = 1'b0;
        `HPSC_HR_CLR_EN:   nxt_r.en_chg = 1'b0;
        `HPSC_HR_CLR_SUSP: nxt_r.susp_chg = 1'b0;
        `HPSC_HR_INT_EN:   nxt_r.int_ep_en = 1'b1;
        default: ;
      endcase
    end

    // Events after requests, so a set beats a same-cycle clear
    if (emb_babble_seen) begin
      nxt_r.en_chg = 1'b1;
      nxt_r.en     = 1'b0;
    end
    if (remote_wake) begin
      if (hub_suspended) nxt_r.wake_pend = 1'b1;
      if (r_ff.susp) begin
        {nxt_r.fn_en, nxt_r.en, nxt_r.susp, nxt_r.susp_chg} = 4'b1101;
      end
    end
  end

  // =========================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r_ff           <= '0;
      r_ff.int_ep_en <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs straight from state flops; slave never waits or errs
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = r_ff.hrdata;
  assign emb_fn_cmd     = r_ff.fn_en;
  assign emb_int_ep_en  = r_ff.int_ep_en;
  assign emb_addr_zero  = r_ff.addr_zero;
  assign link.link_clk  = r_ff.sclk;
  assign link.link_sel  = r_ff.sel;
  assign link.link_mosi = r_ff.mosi;

endmodule : hpsc_ctl

/* File: rtl/hpsc_dev.sv */
// Hub device end: port status query, change flag load, upstream
// resume, frame number read and embedded function babble handling.
// Assumes the controller owns the link clock; the clock, select and
// data-in link pins are synchronised here to sys_clk before use.
`timescale 1ns/1ps
`include "hpsc_params.svh"

// Operation
// - Status query returns status byte first
// - Second read returns same port's change byte
// - Connection bit set while device attached
// - Enabled and suspended bits follow port state
// - Overcurrent common in mode 0, per-port mode 1
// - Reset bit high during 10 ms bus reset
// - Ganged power bit same for every port
// - Low-speed bit flags attached low-speed device
// - Change bits set only on status change
// - Change load writes local and embedded flags
// - Controller writes zero in unused bits
// - Wake command drives upstream resume 10 ms
// - Downstream wake starts resume by itself
// - Frame query returns last good SOF, LSB first
// - Controller handles embedded port reset
// - Controller handles embedded enable and disable
// - Controller handles embedded suspend
// - Controller handles embedded suspend end
// - Controller clears change flags on request
// - Babbling embedded function disabled automatically
// - Controller flags babble as enable change
// - Controller answers remote wakeup while suspended
module hpsc_dev
  import hpsc_pkg::*;
#(
  parameter int unsigned RST_CYC = `HPSC_RESET_CYC,
  parameter int unsigned RES_CYC = `HPSC_RESUME_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Link to the controller
  hpsc_link_if.dev         link,
  // Downstream port state
  input  wire logic [1:0]  dn_connect,
  input  wire logic [1:0]  dn_low_speed,
  input  wire logic [1:0]  dn_enabled,
  input  wire logic [1:0]  dn_suspended,
  input  wire logic [1:0]  dn_overcur,
  input  wire logic        cfg_mode,
  input  wire logic        dn_power,
  input  wire logic [1:0]  dn_bus_reset_req,
  input  wire logic [1:0]  dn_wake,
  // Upstream frame timing
  input  wire logic        sof_ok,
  input  wire logic [10:0] sof_frame,
  // Embedded function
  input  wire logic        emb_fn_cmd,
  input  wire logic        emb_babble,
  // Results
  output logic      [1:0]  dn_bus_reset,
  output logic             up_resume,
  output logic             emb_fn_en,
  output logic      [3:0]  change_map
);

  // =========================================================
  // Elaboration checks
  if (RST_CYC < 2 || RST_CYC > 24'hFFFFFF) begin : g_chk_rst
    $error("hpsc_dev: RST_CYC out of range");
  end
  if (RES_CYC < 2 || RES_CYC > 24'hFFFFFF) begin : g_chk_res
    $error("hpsc_dev: RES_CYC out of range");
  end

  // =========================================================
  // Helpers
  // Assemble one port's status byte
  function automatic logic [7:0] port_status(input logic conn, input logic en, input logic susp,
                                             input logic oc, input logic rst, input logic pwr,
                                             input logic ls);
    logic [7:0] b;
    b                = 8'h00;
    b[`HPSC_ST_CONN] = conn;
    b[`HPSC_ST_EN]   = en;
    b[`HPSC_ST_SUSP] = susp;
    b[`HPSC_ST_OC]   = oc;
    b[`HPSC_ST_RST]  = rst;
    b[`HPSC_ST_PWR]  = pwr;
    b[`HPSC_ST_LS]   = ls & conn;
    return b;
  endfunction : port_status

  // Count a timer down, saturating at zero
  function automatic logic [23:0] count_down(input logic [23:0] c);
    return (c == 24'h000000) ? 24'h000000 : c - 24'h000001;
  endfunction : count_down

  // =========================================================
  // State
  hpsc_dev_st_t r_ff;
  hpsc_dev_st_t nxt_r;

  logic [1:0][7:0] stat;
  logic [1:0]      clr;
  logic            rise;
  logic            sel_fall;
  logic            res_start;
  logic [7:0]      rd_byte;
  logic            is_pstat;

  // =========================================================
  // Next state
  always_comb begin
    nxt_r     = r_ff;
    clr       = 2'b00;
    res_start = 1'b0;
    stat      = '0;
    rd_byte   = 8'h00;

    // Incoming link pins pass two flops before use
    nxt_r.clk_m  = link.link_clk;
    nxt_r.clk_s  = r_ff.clk_m;
    nxt_r.clk_d  = r_ff.clk_s;
    nxt_r.sel_m  = link.link_sel;
    nxt_r.sel_s  = r_ff.sel_m;
    nxt_r.sel_d  = r_ff.sel_s;
    nxt_r.mosi_m = link.link_mosi;
    nxt_r.mosi_s = r_ff.mosi_m;
    rise         = r_ff.clk_s & ~r_ff.clk_d;
    sel_fall     = ~r_ff.sel_s & r_ff.sel_d;

    // Status bytes from live pins and reset timers
    for (int p = 0; p < 2; p++) begin
      stat[p] = port_status(dn_connect[p], dn_enabled[p], dn_suspended[p],
                            cfg_mode ? dn_overcur[p] : dn_overcur[0],
                            r_ff.rst_on[p],
                            dn_power,
                            dn_low_speed[p]);
    end

    // Byte for a read frame, chosen by command and read index
    is_pstat = (r_ff.cmd[7:1] == 7'(`HPSC_CMD_PORT_STAT >> 1));
    if (is_pstat) begin
      if (r_ff.idx == 2'h0) begin
        rd_byte = stat[r_ff.cmd[0]];
      end else if (r_ff.idx == 2'h1) begin
        rd_byte = {1'b0, r_ff.chg[r_ff.cmd[0]]};
      end
    end else if (r_ff.cmd == `HPSC_CMD_FRAME_NUM) begin
      if (r_ff.idx == 2'h0) begin
        rd_byte = r_ff.frame[7:0];
      end else if (r_ff.idx == 2'h1) begin
        rd_byte = {5'h00, r_ff.frame[10:8]};
      end
    end

    // Frame start clears the bit count
    if (r_ff.sel_s & ~r_ff.sel_d) begin
      nxt_r.bitcnt = 4'h0;
    end
    // Shift in on each rising link clock inside a frame
    if (rise & r_ff.sel_s) begin
      nxt_r.rx     = {r_ff.rx[8:0], r_ff.mosi_s};
      nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
      if (r_ff.bitcnt == 4'h1 && {r_ff.rx[0], r_ff.mosi_s} == `HPSC_FT_RD) begin
        nxt_r.tx = rd_byte;
      end else if (r_ff.bitcnt >= 4'h2) begin
        nxt_r.tx = {r_ff.tx[6:0], 1'b0};
      end
    end

    // Act on a complete frame; short frames are dropped
    if (sel_fall && r_ff.bitcnt == `HPSC_FRAME_BITS) begin
      unique case (r_ff.rx[9:8])
        `HPSC_FT_CMD: begin
          nxt_r.cmd = r_ff.rx[7:0];
          nxt_r.idx = 2'h0;
          if (r_ff.rx[7:0] == `HPSC_CMD_RESUME) begin
            res_start = 1'b1;
          end
        end
        `HPSC_FT_WR: begin
          if (r_ff.cmd == `HPSC_CMD_SET_CHG && r_ff.idx == 2'h0) begin
            // Unused bits ignored, controller keeps them zero
            nxt_r.hub_chg = r_ff.rx[1:0];
          end
          nxt_r.idx = (r_ff.idx == 2'h3) ? 2'h3 : r_ff.idx + 2'h1;
        end
        `HPSC_FT_RD: begin
          if (is_pstat && r_ff.idx == 2'h1) begin
            clr[r_ff.cmd[0]] = 1'b1;           // Change byte read clears it
          end
          nxt_r.idx = (r_ff.idx == 2'h3) ? 2'h3 : r_ff.idx + 2'h1;
        end
        default: ;
      endcase
    end

    // Change tracking and bus reset timers per port
    for (int p = 0; p < 2; p++) begin
      nxt_r.prev[p] = stat[p][6:0];
      // Fresh change wins over a clear in the same cycle
      nxt_r.chg[p]  = (clr[p] ? 7'h00 : r_ff.chg[p]) | (stat[p][6:0] ^ r_ff.prev[p]);
      if (dn_bus_reset_req[p]) begin
        nxt_r.rst_cnt[p] = 24'(RST_CYC);
      end else begin
        nxt_r.rst_cnt[p] = count_down(r_ff.rst_cnt[p]);
      end
      nxt_r.rst_on[p] = (nxt_r.rst_cnt[p] != 24'h000000);
    end

    // Upstream resume, by command or any downstream wake
    if (res_start | (|dn_wake)) begin
      nxt_r.res_cnt = 24'(RES_CYC);
    end else begin
      nxt_r.res_cnt = count_down(r_ff.res_cnt);
    end
    nxt_r.resume = (nxt_r.res_cnt != 24'h000000);

    // Frame number of last clean SOF
    if (sof_ok) begin
      nxt_r.frame = sof_frame;
    end

    // Babble latches off the function until enable is withdrawn
    nxt_r.babbled = emb_babble | (r_ff.babbled & emb_fn_cmd);
    nxt_r.emb_en  = emb_fn_cmd & ~nxt_r.babbled;

    // Hub change report merges controller flags with port changes
    nxt_r.chg_map = {|r_ff.chg[1], |r_ff.chg[0], r_ff.hub_chg[`HPSC_CHG_EMB],
                     r_ff.hub_chg[`HPSC_CHG_LOCAL]};
  end

  // =========================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs straight from state flops
  assign link.link_miso = r_ff.tx[7];
  assign dn_bus_reset   = r_ff.rst_on;
  assign up_resume      = r_ff.resume;
  assign emb_fn_en      = r_ff.emb_en;
  assign change_map     = r_ff.chg_map;

endmodule : hpsc_dev

/* File: rtl/hpsc_link_if.sv */
// Serial command link between the hub device and its controller.
// Controller drives clock, frame select and data out; device answers.
`timescale 1ns/1ps
interface hpsc_link_if;
  logic link_clk;
  logic link_sel;
  logic link_mosi;
  logic link_miso;

  // =========================================================
  // One modport for each end
  modport dev (input link_clk, input link_sel, input link_mosi, output link_miso);
  modport ctl (output link_clk, output link_sel, output link_mosi, input link_miso);
endinterface : hpsc_link_if

/* File: rtl/hpsc_params.svh */
// Constants shared by the hub port status command ends.
// Assumes a 100 MHz system clock on both ends of the link.
`ifndef HPSC_PARAMS_SVH
`define HPSC_PARAMS_SVH

// =========================================================
// Command codes (one command byte opens each transaction)
`define HPSC_CMD_PORT_STAT 8'hE0
`define HPSC_CMD_FRAME_NUM 8'hF5
`define HPSC_CMD_RESUME    8'hF6
`define HPSC_CMD_SET_CHG   8'hF7

// =========================================================
// Port status byte and change byte bit positions
`define HPSC_ST_CONN  0
`define HPSC_ST_EN    1
`define HPSC_ST_SUSP  2
`define HPSC_ST_OC    3
`define HPSC_ST_RST   4
`define HPSC_ST_PWR   5
`define HPSC_ST_LS    6
// Change flag load data bits
`define HPSC_CHG_LOCAL 0
`define HPSC_CHG_EMB   1

// =========================================================
// Link framing: two type bits then eight data bits, MSB first
`define HPSC_FT_CMD     2'h0
`define HPSC_FT_WR      2'h1
`define HPSC_FT_RD      2'h2
`define HPSC_FRAME_BITS 4'hA
`define HPSC_HALF_CYC   4'h8
`define HPSC_LAST_HC    5'h17

// =========================================================
// Timing
`define HPSC_CLK_MHZ     100
`define HPSC_T_RESET_US  10000
`define HPSC_T_RESUME_US 10000
`define HPSC_RESET_CYC   (`HPSC_T_RESET_US * `HPSC_CLK_MHZ)
`define HPSC_RESUME_CYC  (`HPSC_T_RESUME_US * `HPSC_CLK_MHZ)

// =========================================================
// Controller register map (byte addresses)
`define HPSC_A_CTRL 8'h00
`define HPSC_A_STAT 8'h04
`define HPSC_A_RDAT 8'h08
`define HPSC_A_HREQ 8'h0C
`define HPSC_A_EMB  8'h10
// Operation codes in CTRL[2:0]
`define HPSC_OP_PSTAT  3'h1
`define HPSC_OP_SETCHG 3'h2
`define HPSC_OP_RESUME 3'h3
`define HPSC_OP_FRAME  3'h4
// CTRL field positions
`define HPSC_CTRL_PORT  3
`define HPSC_CTRL_TWO   4
`define HPSC_CTRL_LPWR  5
// Host request codes in HREQ[3:0]
`define HPSC_HR_RESET    4'h1
`define HPSC_HR_ENABLE   4'h2
`define HPSC_HR_DISABLE  4'h3
`define HPSC_HR_SUSPEND  4'h4
`define HPSC_HR_RESUME   4'h5
`define HPSC_HR_CLR_RST  4'h6
`define HPSC_HR_CLR_EN   4'h7
`define HPSC_HR_CLR_SUSP 4'h8
`define HPSC_HR_INT_EN   4'h9

`endif

/* File: rtl/hpsc_pkg.sv */
// Types for both ends of the hub port status command link.
// Assumes hpsc_params.svh for every number.
package hpsc_pkg;

  // =========================================================
  // Device end state
  typedef struct packed {
    logic             clk_m, clk_s, clk_d;
    logic             sel_m, sel_s, sel_d;
    logic             mosi_m, mosi_s;
    logic [3:0]       bitcnt;
    logic [9:0]       rx;
    logic [7:0]       tx;
    logic [7:0]       cmd;
    logic [1:0]       idx;
    logic [1:0][6:0]  prev;
    logic [1:0][6:0]  chg;
    logic [1:0][23:0] rst_cnt;
    logic [1:0]       rst_on;
    logic [23:0]      res_cnt;
    logic             resume;
    logic [10:0]      frame;
    logic             babbled;
    logic             emb_en;
    logic [1:0]       hub_chg;
    logic [3:0]       chg_map;
  } hpsc_dev_st_t;

  // =========================================================
  // Controller end state
  typedef struct packed {
    logic        miso_m, miso_s;
    logic        busy;
    logic [3:0]  div;
    logic [4:0]  hc;
    logic [1:0]  fidx;
    logic [1:0]  fcnt;
    logic        rd;
    logic [7:0]  cmdb;
    logic [7:0]  wdat;
    logic [7:0]  rx;
    logic [15:0] rdata;
    logic        sclk, sel, mosi;
    logic        ahb_wr;
    logic [7:0]  ahb_addr;
    logic [31:0] hrdata;
    logic        en, susp, rst_chg, en_chg, susp_chg;
    logic        fn_en, int_ep_en, addr_zero;
    logic        wake_pend;
  } hpsc_ctl_st_t;

endpackage : hpsc_pkg

/* File: tb/hpsc_assertions.sv */
// Link wire checker for the hub status command link.
// Assumes one sys_clk domain and the controller owning link_clk.
`timescale 1ns/1ps
module hpsc_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Link wires
  input wire logic link_clk,
  input wire logic link_sel,
  input wire logic link_mosi,
  input wire logic link_miso
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [3:0] rise_ff;
  // ========================================
  // Rising clock edges seen inside a frame
  always_ff @(posedge sys_clk) begin
    rise_ff <= (srst || !link_sel) ? 4'h0 : rise_ff + 4'($rose(link_clk));
  end
  chk_idle_clk: assert property (!link_sel |-> !link_clk)
    else $error("link clock high outside a frame");
  chk_ten_bits: assert property ($fell(link_sel) |-> rise_ff == 4'hA)
    else $error("frame without ten bits");
  chk_half_high: assert property ($rose(link_clk) |-> link_clk[*8] ##1 !link_clk)
    else $error("link clock high half wrong");
  chk_lead_low: assert property ($rose(link_sel) |-> !link_clk[*8] ##1 link_clk)
    else $error("first clock rise misplaced");
  chk_mosi_hold: assert property (link_clk && $past(link_clk) |-> $stable(link_mosi))
    else $error("mosi moved while clock high");
  chk_miso_shift: assert property ($changed(link_miso) && link_sel |-> link_clk)
    else $error("miso moved while clock low");
  chk_frame_len: assert property ($rose(link_sel) |-> ##160 link_sel ##[1:16] !link_sel)
    else $error("frame length wrong");
  chk_frame_gap: assert property ($fell(link_sel) |-> !link_sel[*8])
    else $error("gap between frames too short");
  // Main traffic seen at all
  cover property ($rose(link_sel));
  cover property ($fell(link_sel) && rise_ff == 4'hA);
  cover property (link_sel && link_miso && $rose(link_clk));
endmodule : hpsc_assertions

/* File: tb/tb.sv */
// Bench joining the hub device end and its controller end.
// Assumes timers shortened to 50 cycles on the device end.
`timescale 1ns/1ps
`include "hpsc_params.svh"
module tb;
  logic sys_clk = 0, srst = 1, cfg_mode = 0, dn_power = 0, sof_ok = 0, emb_babble = 0;
  logic remote_wake = 0, hub_suspended = 0, hwrite = 0, hsel = 1;
  logic [1:0] dn_connect = 0, dn_low_speed = 0, dn_enabled = 0, dn_suspended = 0, dn_overcur = 0;
  logic [1:0] dn_bus_reset_req = 0, dn_wake = 0, htrans = 0, dn_bus_reset;
  logic [2:0] hsize = 3'h2;
  logic [10:0] sof_frame = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, seed = 32'h20;
  logic [3:0] change_map;
  logic up_resume, emb_fn_en, emb_fn_cmd, hreadyout, hresp, emb_int_ep_en, emb_addr_zero;
  logic [7:0] last [2] = '{8'h0, 8'h0};
  logic [7:0] chg [2] = '{8'h0, 8'h0};
  logic [3:0] hcode [9] = '{4'h1, 4'h9, 4'h2, 4'h4, 4'h5, 4'h3, 4'h6, 4'h8, 4'h2};
  logic [6:0] hexp [9] = '{7'h24, 7'h64, 7'h65, 7'h46, 7'h75, 7'h54, 7'h50, 7'h40, 7'h61};
  wire [2:0] w = {dn_bus_reset, up_resume};
  int fails = 0, n_tests = 0, n;
  hpsc_link_if lk ();
  hpsc_dev #(.RST_CYC(50), .RES_CYC(50)) hpsc_dev_i (.sys_clk, .srst, .link(lk), .dn_connect, .dn_low_speed,
    .dn_enabled, .dn_suspended, .dn_overcur, .cfg_mode, .dn_power, .dn_bus_reset_req, .dn_wake, .sof_ok,
    .sof_frame, .emb_fn_cmd, .emb_babble, .dn_bus_reset, .up_resume, .emb_fn_en, .change_map);
  hpsc_ctl hpsc_ctl_i (.sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .remote_wake, .hub_suspended, .emb_babble_seen(emb_babble), .emb_fn_cmd,
    .emb_int_ep_en, .emb_addr_zero, .link(lk));
  hpsc_assertions hpsc_assertions_i (.sys_clk, .srst, .link_clk(lk.link_clk), .link_sel(lk.link_sel),
    .link_mosi(lk.link_mosi), .link_miso(lk.link_miso));
  // ========================================
  // Clock and helpers
  always #5 sys_clk = ~sys_clk;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Expected status byte; low speed hidden when nothing attached
  function logic [7:0] st(int p);
    return {1'b0, dn_low_speed[p] & dn_connect[p], dn_power, 1'b0, cfg_mode ? dn_overcur[p] : dn_overcur[0],
            dn_suspended[p], dn_enabled[p], dn_connect[p]};
  endfunction : st
  task chk(string s, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One single AHB-Lite word transfer, waiting on hready
  task bus(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // Busy flag lands two cycles after the write, hence the pause
  task op(logic [31:0] c);
    bus(1'b1, `HPSC_A_CTRL, c);
    repeat (2) @(posedge sys_clk);
    do bus(1'b0, `HPSC_A_STAT, 0); while (rd[0] !== 1'b0);
    bus(1'b0, `HPSC_A_RDAT, 0);
  endtask : op
  task hq(logic [3:0] c, logic [6:0] e);
    bus(1'b1, `HPSC_A_HREQ, {28'h0, c});
    @(posedge sys_clk);
    chk("addr zero", c == 4'h1, emb_addr_zero);
    bus(1'b0, `HPSC_A_EMB, 0);
    chk("emb", e, rd[6:0]);
    chk("int ep", e[6], emb_int_ep_en);
    chk("resp", 0, hresp);
  endtask : hq
  // Length of a level pulse; start bounded, end left to the watchdog
  task dur(int s);
    n = 0;
    for (int i = 0; i < 400 && w[s] !== 1'b1; i++) @(posedge sys_clk);
    while (w[s] === 1'b1) begin
      n++;
      @(posedge sys_clk);
    end
  endtask : dur
  task report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    #400_000;
    fails++;
    report_and_stop();
  end
  // ========================================
  // Scenarios
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      {dn_connect, dn_low_speed, dn_enabled, dn_suspended, dn_overcur, cfg_mode, dn_power} <= 12'(rnd());
      if (i == 7) dn_bus_reset_req <= 2'h2;
      @(posedge sys_clk);
      dn_bus_reset_req <= 2'h0;
      @(posedge sys_clk);
      if (i == 7) dur(2);
      if (i == 7) chk("reset len", 50, n);
      if (i == 7) chg[1][4] = 1'b1;
      for (int p = 0; p < 2; p++) begin
        chg[p] |= st(p) ^ last[p];
        last[p] = st(p);
        op({27'h0, i[0], p[0], `HPSC_OP_PSTAT});
        chk("status", last[p], rd[7:0]);
        if (i[0]) chk("change", chg[p], rd[15:8]);
        if (i[0]) chg[p] = 8'h0;
      end
    end
    dn_wake <= 2'h1;
    @(posedge sys_clk);
    dn_wake <= 2'h0;
    dur(0);
    chk("wake len", 50, n);
    bus(1'b1, `HPSC_A_CTRL, {29'h0, `HPSC_OP_RESUME});
    dur(0);
    chk("resume len", 50, n);
    sof_frame <= 11'(rnd());
    sof_ok <= 1'b1;
    @(posedge sys_clk);
    sof_ok <= 1'b0;
    op({27'h0, 2'h2, `HPSC_OP_FRAME});
    chk("frame", {5'h0, sof_frame}, rd[15:0]);
    for (int k = 0; k < 9; k++) begin
      hq(hcode[k], hexp[k]);
      chk("fn en", hexp[k][5], emb_fn_en);
    end
    emb_babble <= 1'b1;
    @(posedge sys_clk);
    emb_babble <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("babble fn", 0, emb_fn_en);
    bus(1'b0, `HPSC_A_EMB, 0);
    chk("babble emb", 5'h08, rd[4:0]);
    for (int lp = 0; lp < 2; lp++) begin
      op({26'h0, lp[0], 2'h0, `HPSC_OP_SETCHG});
      chk("chg map", {|chg[1], |chg[0], 1'b1, lp[0]}, change_map);
    end
    hub_suspended <= 1'b1;
    bus(1'b1, `HPSC_A_HREQ, {28'h0, `HPSC_HR_SUSPEND});
    remote_wake <= 1'b1;
    @(posedge sys_clk);
    remote_wake <= 1'b0;
    dur(0);
    chk("remote wake", 50, n);
    bus(1'b0, `HPSC_A_EMB, 0);
    chk("wake emb", 5'h19, rd[4:0]);
    hq(4'h7, 7'h71);
    report_and_stop();
  end
endmodule : tb
